//--- common/delay_link_pkg.sv
// Constants shared by both ends of the delay-setting link.
// Assumes a 25 MHz host clock and a link clock made by the host's divider.
package delay_link_pkg;
    // ==========================================================
    // Setting and chain
    localparam int SETTING_W = 8;
    localparam int SETTING_STEPS = 256;
    localparam int CHAIN_LEN = 1;
    localparam int CHAIN_BITS = SETTING_W * CHAIN_LEN;
    localparam int BITCNT_W = 5;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_HALF = 4;
    localparam int SCLK_PERIOD_NS = 2 * SCLK_HALF * CLK_PERIOD_NS;
    localparam int LATCH_SETTLE_NS = 100;
    localparam int INPUT_SETTLE_NS = 100;
    localparam int LATCH_SETTLE_CYC = (LATCH_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int INPUT_SETTLE_CYC = (INPUT_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int DEV_SETTLE_CYC =
        (LATCH_SETTLE_NS + SCLK_PERIOD_NS - 1) / SCLK_PERIOD_NS;
    localparam int SETTLE_W = 8;
    localparam int PHASE_W = 3;
    // ==========================================================
    // Host register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PAR = 4'h1;
    localparam logic [3:0] REG_TX = 4'h2;
    localparam logic [3:0] REG_CMD = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RX = 4'h5;
    localparam int CTRL_SERIAL = 0;
    localparam int CTRL_FUNC = 1;
    localparam int CTRL_LATCH = 2;
    localparam int CTRL_W = 3;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_SERIAL = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] SETTING_RESET = 8'h00;
endpackage

//--- common/delay_link_if.sv
// Pins between the host controller and the delay-setting device.
// Host-driven wires change only around the falling edge of sclk; sdo moves on the rise.
`timescale 1ns/1ps
`default_nettype none
interface delay_link_if;
    import delay_link_pkg::*;
    logic sclk;
    logic latch_enable_in;
    logic serial_select;
    logic function_select;
    logic sdi;
    logic sdo;
    logic [SETTING_W-1:0] parallel_setting_inputs;

    modport device (
        input sclk,
        input latch_enable_in,
        input serial_select,
        input function_select,
        input sdi,
        input parallel_setting_inputs,
        output sdo
    );
    modport host (
        output sclk,
        output latch_enable_in,
        output serial_select,
        output function_select,
        output sdi,
        output parallel_setting_inputs,
        input sdo
    );
endinterface
`default_nettype wire

//--- design/bit_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input is a level from another clock domain.
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Level
    input wire logic d,
    output logic q
);
    logic stage1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            q <= 1'b0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- design/delay_setting_device.sv
// Device end: the 8-bit delay setting with parallel and serial loading.
// Assumes every host-driven link pin changes only while sclk is low, so all of them
// belong to the sclk domain and need no synchroniser here.
// Reset is asynchronous and released while sclk is held low.
`timescale 1ns/1ps
`default_nettype none
module delay_setting_device
    import delay_link_pkg::*;
(
    // Link
    delay_link_if.device link,
    // Reset
    input wire logic rst_b,
    // Active setting
    output logic [SETTING_W-1:0] delay_setting,
    output logic setting_settled,
    // Mode as seen at the pins
    output logic delay_line_mode,
    output logic serial_mode,
    // Serial transfer progress
    output logic [BITCNT_W-1:0] bits_shifted
);
    // ==========================================================
    // Input shift register
    logic [SETTING_W-1:0] shift_reg;
    logic shift_en;
    // Framing
    logic latch_q;
    logic serial_q;
    logic apply_serial;
    // Active setting and settling
    logic follow_parallel;
    logic settle_start;
    logic [SETTING_W-1:0] next_setting;
    logic [SETTING_W-1:0] step_index;
    logic [SETTING_W:0] step_count;
    logic [SETTLE_W-1:0] settle_cnt;

    assign shift_en = link.serial_select & link.latch_enable_in;

    // Each bit takes its lower neighbour; bit 0 takes the serial input
    for (genvar i = 0; i < SETTING_W; i++) begin : g_bit
        if (i == 0) begin : g_first
            always_ff @(posedge link.sclk or negedge rst_b) begin
                if (!rst_b) begin
                    shift_reg[i] <= 1'b0;
                end else if (shift_en) begin
                    shift_reg[i] <= link.sdi;
                end
            end
        end else begin : g_rest
            always_ff @(posedge link.sclk or negedge rst_b) begin
                if (!rst_b) begin
                    shift_reg[i] <= 1'b0;
                end else if (shift_en) begin
                    shift_reg[i] <= shift_reg[i-1];
                end
            end
        end
    end

    // ==========================================================
    // Serial output
    // Top bit leaves first, so a chain sees the old value MSB first;
    // it comes straight from a flop, so it only moves on the rise
    assign link.sdo = shift_reg[SETTING_W-1];

    // ==========================================================
    // End of transfer
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= link.latch_enable_in;
        end
    end

    // Mode seen at the previous rise: leaving latched parallel mode also
    // drops latch enable, and must not pass for the end of a frame
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            serial_q <= 1'b0;
        end else begin
            serial_q <= link.serial_select;
        end
    end

    // Falling enable seen at the first sclk edge after it drops;
    // a short frame still applies, since the host owns the count
    assign apply_serial = link.serial_select & serial_q & latch_q &
                          ~link.latch_enable_in;

    // ==========================================================
    // Shift count
    // Saturates, so a long chained frame never reads as a short one
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            bits_shifted <= '0;
        end else if (shift_en && !latch_q) begin
            bits_shifted <= BITCNT_W'(1);
        end else if (shift_en && bits_shifted != '1) begin
            bits_shifted <= bits_shifted + BITCNT_W'(1);
        end
    end

    // ==========================================================
    // Active setting
    // Parallel latch is sampled on sclk rather than truly transparent;
    // the host keeps sclk running so the lag is one sclk period at most.
    assign follow_parallel = ~link.serial_select &
                             link.latch_enable_in;

    always_comb begin
        next_setting = delay_setting;
        if (follow_parallel) begin
            next_setting = link.parallel_setting_inputs;
        end else if (apply_serial) begin
            next_setting = shift_reg;
        end
    end

    // ==========================================================
    // Setting register
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            delay_setting <= SETTING_RESET;
        end else begin
            delay_setting <= next_setting;
        end
    end

    // ==========================================================
    // Step selection
    // Step count stays inside the 256 available steps
    // and keeps the settled flag honest should the width ever grow
    assign step_index = delay_setting;
    assign step_count = {1'b0, step_index} + (SETTING_W+1)'(1);

    // ==========================================================
    // Settling indication
    // Counted on sclk, so it is only meaningful while sclk runs.
    // Every serial apply restarts it, even when the value repeats.
    assign settle_start = apply_serial | (next_setting != delay_setting);

    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt <= '0;
        end else if (settle_start) begin
            settle_cnt <= SETTLE_W'(DEV_SETTLE_CYC);
        end else if (settle_cnt != '0) begin
            settle_cnt <= settle_cnt - SETTLE_W'(1);
        end
    end

    // Flag drops as settling starts and rises as the count runs out
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            setting_settled <= 1'b1;
        end else if (settle_start) begin
            setting_settled <= 1'b0;
        end else if (settle_cnt != '0) begin
            setting_settled <= (settle_cnt == SETTLE_W'(1)) &&
                               (step_count <= (SETTING_W+1)'(SETTING_STEPS));
        end
    end

    // ==========================================================
    // Function select
    // Both mode flags lag their pins by one rise
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            delay_line_mode <= 1'b1;
        end else begin
            delay_line_mode <= ~link.function_select;
        end
    end

    // ==========================================================
    // Programming mode
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            serial_mode <= 1'b0;
        end else begin
            serial_mode <= link.serial_select;
        end
    end
endmodule
`default_nettype wire

//--- design/delay_setting_host.sv
// Host end: drives the delay-setting link from a small register port.
// Assumes software on clk; the link is paced by a divided clock made here.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module delay_setting_host
    import delay_link_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Status
    output logic busy,
    // Link
    delay_link_if.host link
);
    typedef enum {S_IDLE, S_SHIFT, S_SETTLE} host_state_t;
    host_state_t state;
    logic [CTRL_W-1:0] ctrl;
    logic [SETTING_W-1:0] par_data;
    logic [CHAIN_BITS-1:0] tx_data;
    logic [CHAIN_BITS-1:0] tx_shift;
    logic [CHAIN_BITS-1:0] rx_data;
    logic write_req;
    logic read_req;
    logic read_back;
    logic [BITCNT_W-1:0] bit_cnt;
    logic [SETTLE_W-1:0] settle_cnt;
    logic [PHASE_W-1:0] phase;
    logic sclk_q;
    logic fall_tick;
    logic sdo_s;
    logic le_q;
    logic sel_q;
    logic func_q;
    logic sdi_q;
    logic [SETTING_W-1:0] par_q;
    logic cmd_wr;
    logic start;

    // ==========================================================
    // Link clock divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= '0;
            sclk_q <= 1'b0;
        end else if (phase == PHASE_W'(SCLK_HALF - 1)) begin
            phase <= '0;
            sclk_q <= ~sclk_q;
        end else begin
            phase <= phase + PHASE_W'(1);
        end
    end

    // Link pins only move as sclk falls, far from the device's edge
    assign fall_tick = sclk_q && (phase == PHASE_W'(SCLK_HALF - 1));

    bit_sync u_sdo_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(link.sdo),
        .q(sdo_s)
    );

    // ==========================================================
    // Register port
    assign cmd_wr = wr && (addr == REG_CMD);
    assign start = fall_tick && (state == S_IDLE) && sel_q &&
                   (write_req || read_req);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            par_data <= SETTING_RESET;
            tx_data <= '0;
        end else if (wr) begin
            case (addr)
                REG_CTRL: ctrl <= wdata[CTRL_W-1:0];
                REG_PAR: par_data <= wdata[SETTING_W-1:0];
                REG_TX: tx_data <= wdata[CHAIN_BITS-1:0];
                default: ctrl <= ctrl;
            endcase
        end
    end

    // A new command in the start cycle is kept: set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_req <= 1'b0;
            read_req <= 1'b0;
        end else if (cmd_wr) begin
            write_req <= write_req | wdata[CMD_WRITE];
            read_req <= read_req | wdata[CMD_READ];
        end else if (start) begin
            write_req <= 1'b0;
            read_req <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                REG_CTRL: rdata <= 8'(ctrl);
                REG_PAR: rdata <= par_data;
                REG_TX: rdata <= tx_data;
                REG_STATUS: rdata <= 8'(sel_q) << ST_SERIAL |
                                     8'(busy) << ST_BUSY;
                REG_RX: rdata <= rx_data;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ==========================================================
    // Transfer sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            bit_cnt <= '0;
            settle_cnt <= '0;
            tx_shift <= '0;
            rx_data <= '0;
            read_back <= 1'b0;
            le_q <= 1'b0;
            sel_q <= 1'b0;
            func_q <= 1'b0;
            sdi_q <= 1'b0;
            par_q <= SETTING_RESET;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state <= S_SHIFT;
                        bit_cnt <= '0;
                        tx_shift <= tx_data;
                        read_back <= read_req && !write_req;
                    end else if (fall_tick) begin
                        sel_q <= ctrl[CTRL_SERIAL];
                        func_q <= ctrl[CTRL_FUNC];
                        le_q <= ~ctrl[CTRL_SERIAL] &
                                ctrl[CTRL_LATCH];
                        par_q <= par_data;
                        if (!ctrl[CTRL_SERIAL] && ctrl[CTRL_LATCH] &&
                            par_data != par_q) begin
                            state <= S_SETTLE;
                            settle_cnt <= SETTLE_W'(INPUT_SETTLE_CYC);
                        end
                    end
                end
                S_SHIFT: begin
                    if (fall_tick) begin
                        if (bit_cnt != BITCNT_W'(CHAIN_BITS)) begin
                            le_q <= 1'b1;
                            // Read-back returns each output bit
                            sdi_q <= read_back ? sdo_s :
                                     tx_shift[CHAIN_BITS-1];
                            tx_shift <= tx_shift << 1;
                            rx_data <= {rx_data[CHAIN_BITS-2:0], sdo_s};
                            bit_cnt <= bit_cnt + BITCNT_W'(1);
                        end else begin
                            le_q <= 1'b0;
                            state <= S_SETTLE;
                            settle_cnt <= SETTLE_W'(LATCH_SETTLE_CYC);
                        end
                    end
                end
                S_SETTLE: begin
                    // One extra sclk after the fall lets the device apply
                    if (settle_cnt != '0) begin
                        settle_cnt <= settle_cnt - SETTLE_W'(1);
                    end else if (fall_tick) begin
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
        end else begin
            busy <= (state != S_IDLE) || start || write_req || read_req;
        end
    end

    assign link.sclk = sclk_q;
    assign link.latch_enable_in = le_q;
    assign link.serial_select = sel_q;
    assign link.function_select = func_q;
    assign link.sdi = sdi_q;
    assign link.parallel_setting_inputs = par_q;
endmodule
`default_nettype wire

//--- tb/delay_setting_load_port_chk.sv
// Checker: relations on the delay-setting link and the device's setting.
// Assumes it sits beside the link joining the two design ends, on sclk.
`timescale 1ns/1ps
`default_nettype none
module delay_setting_load_port_chk
    import delay_link_pkg::*;
(
    // Reset
    input wire logic rst_b,
    // Link
    input wire logic sclk,
    input wire logic latch_enable_in,
    input wire logic serial_select,
    input wire logic function_select,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic [SETTING_W-1:0] parallel_setting_inputs,
    // Device side
    input wire logic [SETTING_W-1:0] delay_setting,
    input wire logic setting_settled,
    input wire logic delay_line_mode,
    input wire logic serial_mode,
    input wire logic [BITCNT_W-1:0] bits_shifted
);
    // Armed from the second sclk rise, once $past has a real history
    logic armed;

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end

    // ==========================================================
    // Serial framing
    frame_len_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        $rose(latch_enable_in) && serial_select
        |-> latch_enable_in [*8] ##1 !latch_enable_in)
        else $error("serial frame is not eight clocks long");
    sdo_pass_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        $fell(latch_enable_in) && serial_select |-> sdo == $past(sdi, 8))
        else $error("first bit in did not reach the serial output");
    bit_count_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        $fell(latch_enable_in) && serial_select |-> bits_shifted == 5'h08)
        else $error("shift count wrong at frame end");
    sel_hold_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        latch_enable_in && $past(latch_enable_in) |-> $stable(serial_select))
        else $error("mode select moved inside a frame");
    // ==========================================================
    // Active setting
    shift_hold_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        serial_select && $past(serial_select) && $past(latch_enable_in)
        |-> $stable(delay_setting))
        else $error("setting moved while shifting");
    serial_apply_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        $fell(latch_enable_in) && serial_select
        |=> delay_setting[7] == $past(sdi, 9)
            && delay_setting[0] == $past(sdi, 2))
        else $error("shifted value not applied msb first");
    settle_pulse_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        $fell(latch_enable_in) && serial_select
        |=> !setting_settled ##1 setting_settled)
        else $error("settled flag did not pulse after apply");
    par_follow_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        !serial_select && latch_enable_in
        |=> delay_setting == $past(parallel_setting_inputs))
        else $error("parallel setting not followed");
    par_freeze_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        !serial_select && !latch_enable_in && !$past(latch_enable_in)
        |=> $stable(delay_setting))
        else $error("parallel setting moved while latched");
    mode_track_a: assert property (
        @(posedge sclk) disable iff (!rst_b)
        armed |-> serial_mode == $past(serial_select)
        && delay_line_mode == !$past(function_select))
        else $error("mode outputs do not track the pins");
endmodule
`default_nettype wire

//--- tb/delay_setting_load_port_tb.sv
// Testbench: host and device joined by the link, plus a bench-driven device.
// Assumes the package map of the host's register port.
`timescale 1ns/1ps
`default_nettype none
module delay_setting_load_port_tb;
    import delay_link_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic busy;
    logic [7:0] delay_setting;
    logic [7:0] ds2;
    logic setting_settled;
    logic delay_line_mode;
    logic serial_mode;
    logic [BITCNT_W-1:0] bits_shifted;
    int errors = 0;
    int checks = 0;
    // Rows: value sent, then old value expected back on the output
    logic [15:0] rows [6] = '{16'ha500, 16'h5aa5, 16'hff5a, 16'h00ff,
                              16'h8000, 16'h0180};
    delay_link_if link();
    delay_link_if link2();
    delay_setting_host delay_setting_host_inst (.clk(clk), .rst_b(rst_b),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .busy(busy), .link(link));
    delay_setting_device delay_setting_device_inst (.link(link),
        .rst_b(rst_b), .delay_setting(delay_setting),
        .setting_settled(setting_settled), .delay_line_mode(delay_line_mode),
        .serial_mode(serial_mode), .bits_shifted(bits_shifted));
    // Second device: the bench plays a host that writes a short frame
    delay_setting_device delay_setting_device_inst2 (.link(link2),
        .rst_b(rst_b), .delay_setting(ds2), .setting_settled(),
        .delay_line_mode(), .serial_mode(), .bits_shifted());
    delay_setting_load_port_chk delay_setting_load_port_chk_inst (
        .rst_b(rst_b), .sclk(link.sclk),
        .latch_enable_in(link.latch_enable_in),
        .serial_select(link.serial_select),
        .function_select(link.function_select), .sdi(link.sdi),
        .sdo(link.sdo), .parallel_setting_inputs(link.parallel_setting_inputs),
        .delay_setting(delay_setting), .setting_settled(setting_settled),
        .delay_line_mode(delay_line_mode), .serial_mode(serial_mode),
        .bits_shifted(bits_shifted));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // Tasks
    task automatic conclude;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e,
                        input string n);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(n, e, rdata);
        @(posedge clk);
    endtask
    task automatic wait_idle;
        int i;
        @(negedge clk);
        for (i = 0; i < 400; i++) begin
            if (busy === 1'b0) break;
            @(negedge clk);
        end
        if (i == 400) begin
            errors++;
            $display("[FAIL] busy expected 0 seen 1");
            conclude();
        end
        @(posedge clk);
    endtask
    // Link clock pulses inside a frame and once more after enable drops
    task automatic shift2(input logic b);
        link2.sdi = b;
        #80 link2.sclk = 1'b1;
        #80 link2.sclk = 1'b0;
    endtask
    task automatic frame2(input logic [7:0] v, input int n);
        link2.latch_enable_in = 1'b1;
        for (int i = 0; i < n; i++) shift2(v[7-i]);
        link2.latch_enable_in = 1'b0;
        shift2(~v[0]);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst_b <= 1'b0;
        link2.sclk = 1'b0;
        link2.latch_enable_in = 1'b0;
        link2.serial_select = 1'b1;
        link2.function_select = 1'b0;
        link2.sdi = 1'b0;
        link2.parallel_setting_inputs = 8'h00;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk("reset setting", SETTING_RESET, delay_setting);
        chk("reset settled", 8'h01, {7'h0, setting_settled});
        chk("reset line mode", 8'h01, {7'h0, delay_line_mode});
        chk("reset serial mode", 8'h00, {7'h0, serial_mode});
        rreg(REG_CTRL, 8'h00, "reset ctrl");
        rreg(REG_STATUS, 8'h00, "reset status");
        $display("reset test done");
        wreg(REG_CTRL, 8'h01);
        foreach (rows[k]) begin
            wreg(REG_TX, rows[k][15:8]);
            wreg(REG_CMD, 8'h01);
            wait_idle();
            chk("serial setting", rows[k][15:8], delay_setting);
            rreg(REG_RX, rows[k][7:0], "old value out");
        end
        $display("serial rows done");
        rreg(REG_STATUS, 8'h02, "status serial");
        wreg(REG_CMD, 8'h02);
        wait_idle();
        chk("readback keeps", 8'h01, delay_setting);
        rreg(REG_RX, 8'h01, "readback value");
        wreg(REG_STATUS, 8'hff);
        rreg(REG_STATUS, 8'h02, "status read only");
        rreg(4'hf, 8'h00, "unmapped read");
        wreg(REG_CTRL, 8'h03);
        repeat (16) @(posedge clk);
        chk("function select", 8'h00, {7'h0, delay_line_mode});
        chk("serial mode", 8'h01, {7'h0, serial_mode});
        $display("readback and mode test done");
        wreg(REG_CTRL, 8'h04);
        wreg(REG_PAR, 8'h3c);
        wait_idle();
        repeat (16) @(posedge clk);
        chk("par follow", 8'h3c, delay_setting);
        wreg(REG_CTRL, 8'h00);
        repeat (16) @(posedge clk);
        wreg(REG_PAR, 8'hc3);
        repeat (16) @(posedge clk);
        chk("par frozen", 8'h3c, delay_setting);
        wreg(REG_CTRL, 8'h04);
        repeat (16) @(posedge clk);
        chk("par resumed", 8'hc3, delay_setting);
        $display("parallel test done");
        frame2(8'ha5, 8);
        chk("second full write", 8'ha5, ds2);
        frame2(8'hff, 4);
        chk("partial write", 8'h5f, ds2);
        chk("partial out", 8'h00, {7'h0, link2.sdo});
        $display("partial frame test done");
        conclude();
    end
endmodule
`default_nettype wire
